// file: rtl/uhp_pkg.sv
package uhp_pkg;
    // ------------------------------------------------------------
    // bus styles and pin levels
    // ------------------------------------------------------------
    localparam logic STYLE_SEPARATE = 1'b1;
    localparam logic STYLE_COMBINED = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic IDLE_STANDARD = 1'b1;
    localparam logic IDLE_INFRARED = 1'b0;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 25;
    localparam int SETUP_NS = 40;
    localparam int STROBE_NS = 120;
    localparam int HOLD_NS = 40;
    localparam int SETUP_RAW = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int STROBE_RAW = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int HOLD_RAW = (HOLD_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [3:0] SETUP_CYCLES = 4'(SETUP_RAW < 1 ? 1 : SETUP_RAW);
    localparam logic [3:0] STROBE_CYCLES = 4'(STROBE_RAW < 1 ? 1 : STROBE_RAW);
    localparam logic [3:0] HOLD_CYCLES = 4'(HOLD_RAW < 1 ? 1 : HOLD_RAW);
    localparam logic [3:0] COUNT_ONE = 4'h1;
    localparam logic [3:0] COUNT_ZERO = 4'h0;

    // ------------------------------------------------------------
    // pin synchroniser layout
    // ------------------------------------------------------------
    localparam int SYNC_WIDTH = 10;
    localparam int SYNC_TX = 9;
    localparam int SYNC_ATTENTION = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } uhp_state_e;
endpackage : uhp_pkg

// file: rtl/uhp_sync.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// two flip-flop synchroniser
// ------------------------------------------------------------
module uhp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] first_stage;

    always_ff @(posedge clock) begin
        if (reset) begin
            first_stage <= '0;
            sync_out <= '0;
        end else begin
            first_stage <= async_in;
            sync_out <= first_stage;
        end
    end
endmodule : uhp_sync

// file: rtl/uhp_host.sv
`timescale 1ns/10ps
module uhp_host (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // user command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [2:0] cmd_select,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    output logic cmd_done,
    output logic [7:0] cmd_rdata,
    // user configuration and status
    input wire logic style_separate,
    input wire logic attention_output_enable,
    input wire logic infrared_select,
    output logic attention,
    output logic tx_idle_ok,
    // device pins
    output logic bus_style_strap,
    output logic [2:0] register_select,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    input wire logic attention_pin,
    input wire logic tx_pin
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [uhp_pkg::SYNC_WIDTH-1:0] pins_sync;
    logic [7:0] data_sync;

    uhp_sync #(.WIDTH(uhp_pkg::SYNC_WIDTH)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({tx_pin, attention_pin, host_data_bus_in}),
        .sync_out(pins_sync)
    );
    assign data_sync = pins_sync[7:0];

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    uhp_pkg::uhp_state_e state, next_state;
    logic [3:0] count, next_count;
    logic op_write, next_op_write;
    logic next_strap, next_ready, next_done;
    logic [7:0] next_rdata, next_data_out;
    logic [2:0] next_select;
    logic next_cs_n, next_rd_n, next_wr_n, next_oe_n;

    always_comb begin
        next_state = state;
        next_count = count;
        next_op_write = op_write;
        next_strap = bus_style_strap;
        next_select = register_select;
        next_cs_n = chip_select_n;
        next_rd_n = read_strobe_n;
        next_wr_n = write_strobe_n;
        next_oe_n = host_data_bus_oe_n;
        next_data_out = host_data_bus_out;
        next_rdata = cmd_rdata;
        next_done = 1'b0;
        case (state)
            uhp_pkg::ST_IDLE: begin
                next_strap = style_separate;
                if (cmd_valid) begin
                    next_state = uhp_pkg::ST_SETUP;
                    next_count = uhp_pkg::SETUP_CYCLES;
                    next_op_write = cmd_write;
                    next_select = cmd_select;
                    next_cs_n = 1'b0;
                    next_data_out = cmd_wdata;
                    next_oe_n = ~cmd_write;
                    if (bus_style_strap == uhp_pkg::STYLE_COMBINED) begin
                        next_wr_n = cmd_write ? uhp_pkg::RW_WRITE : uhp_pkg::RW_READ;
                    end
                end
            end
            uhp_pkg::ST_SETUP: begin
                next_count = count - uhp_pkg::COUNT_ONE;
                if (count == uhp_pkg::COUNT_ONE) begin
                    next_state = uhp_pkg::ST_STROBE;
                    next_count = uhp_pkg::STROBE_CYCLES;
                    if (bus_style_strap == uhp_pkg::STYLE_SEPARATE) begin
                        next_rd_n = op_write;
                        next_wr_n = ~op_write;
                    end
                end
            end
            uhp_pkg::ST_STROBE: begin
                next_count = count - uhp_pkg::COUNT_ONE;
                if (count == uhp_pkg::COUNT_ONE) begin
                    next_state = uhp_pkg::ST_HOLD;
                    next_count = uhp_pkg::HOLD_CYCLES;
                    if (!op_write) begin
                        next_rdata = data_sync;
                    end
                    if (bus_style_strap == uhp_pkg::STYLE_SEPARATE) begin
                        next_rd_n = 1'b1;
                        next_wr_n = 1'b1;
                    end else begin
                        next_cs_n = 1'b1;
                    end
                end
            end
            uhp_pkg::ST_HOLD: begin
                next_count = count - uhp_pkg::COUNT_ONE;
                if (count == uhp_pkg::COUNT_ONE) begin
                    next_state = uhp_pkg::ST_IDLE;
                    next_count = uhp_pkg::COUNT_ZERO;
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_wr_n = 1'b1;
                    next_done = 1'b1;
                end
            end
            default: begin
                next_state = uhp_pkg::ST_IDLE;
                next_count = uhp_pkg::COUNT_ZERO;
                next_cs_n = 1'b1;
                next_rd_n = 1'b1;
                next_wr_n = 1'b1;
                next_oe_n = 1'b1;
            end
        endcase
        next_ready = (next_state == uhp_pkg::ST_IDLE);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= uhp_pkg::ST_IDLE;
            count <= uhp_pkg::COUNT_ZERO;
            op_write <= 1'b0;
            bus_style_strap <= uhp_pkg::STYLE_SEPARATE;
            register_select <= uhp_pkg::SELECT_RESET;
            chip_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            host_data_bus_oe_n <= 1'b1;
            host_data_bus_out <= uhp_pkg::DATA_RESET;
            cmd_rdata <= uhp_pkg::DATA_RESET;
            cmd_ready <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            op_write <= next_op_write;
            bus_style_strap <= next_strap;
            register_select <= next_select;
            chip_select_n <= next_cs_n;
            read_strobe_n <= next_rd_n;
            write_strobe_n <= next_wr_n;
            host_data_bus_oe_n <= next_oe_n;
            host_data_bus_out <= next_data_out;
            cmd_rdata <= next_rdata;
            cmd_ready <= next_ready;
            cmd_done <= next_done;
        end
    end

    // ------------------------------------------------------------
    // interrupt decode and transmit idle check
    // ------------------------------------------------------------
    logic next_attention, next_tx_ok, line_attn, line_tx;

    always_comb begin
        line_attn = pins_sync[uhp_pkg::SYNC_ATTENTION];
        line_tx = pins_sync[uhp_pkg::SYNC_TX];
        if (bus_style_strap == uhp_pkg::STYLE_SEPARATE) begin
            next_attention = attention_output_enable & line_attn;
        end else begin
            next_attention = ~line_attn;
        end
        if (infrared_select) begin
            next_tx_ok = (line_tx == uhp_pkg::IDLE_INFRARED);
        end else begin
            next_tx_ok = (line_tx == uhp_pkg::IDLE_STANDARD);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            attention <= 1'b0;
            tx_idle_ok <= 1'b0;
        end else begin
            attention <= next_attention;
            tx_idle_ok <= next_tx_ok;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_read_capture: assert property (@(posedge clock) disable iff (reset)
        (state == uhp_pkg::ST_STROBE && count == uhp_pkg::COUNT_ONE && !op_write)
        |=> (cmd_rdata == $past(data_sync)))
        else $error("read byte not captured at strobe rise");

    a_read_strobe_high: assert property (@(posedge clock) disable iff (reset)
        (bus_style_strap == uhp_pkg::STYLE_COMBINED && state != uhp_pkg::ST_IDLE)
        |-> read_strobe_n)
        else $error("read strobe low in combined style");

    a_rw_line_level: assert property (@(posedge clock) disable iff (reset)
        (bus_style_strap == uhp_pkg::STYLE_COMBINED && !chip_select_n)
        |-> (write_strobe_n == !op_write))
        else $error("read/write line disagrees with operation");

    a_strobe_with_select: assert property (@(posedge clock) disable iff (reset)
        (bus_style_strap == uhp_pkg::STYLE_SEPARATE && !(read_strobe_n && write_strobe_n))
        |-> !chip_select_n)
        else $error("strobe active without chip select");

    a_select_before_strobe: assert property (@(posedge clock) disable iff (reset)
        $fell(read_strobe_n) |-> !$past(chip_select_n))
        else $error("chip select not set up before read strobe");

    a_transfer_done: assert property (@(posedge clock) disable iff (reset)
        (state == uhp_pkg::ST_IDLE && cmd_valid) |-> ##[3:12] cmd_done)
        else $error("transfer did not complete in time");

    a_write_data_drive: assert property (@(posedge clock) disable iff (reset)
        (!write_strobe_n && bus_style_strap == uhp_pkg::STYLE_SEPARATE)
        |-> (!host_data_bus_oe_n && op_write))
        else $error("write strobe without driven data");

    a_open_drain_attn: assert property (@(posedge clock) disable iff (reset)
        (bus_style_strap == uhp_pkg::STYLE_COMBINED && $stable(bus_style_strap)
        && !pins_sync[uhp_pkg::SYNC_ATTENTION]) |=> attention)
        else $error("low interrupt line not reported");

    c_read_separate: cover property (@(posedge clock) disable iff (reset)
        $rose(read_strobe_n) && bus_style_strap == uhp_pkg::STYLE_SEPARATE);
    c_write_separate: cover property (@(posedge clock) disable iff (reset)
        $rose(write_strobe_n) && bus_style_strap == uhp_pkg::STYLE_SEPARATE);
    c_read_combined: cover property (@(posedge clock) disable iff (reset)
        cmd_done && !op_write && bus_style_strap == uhp_pkg::STYLE_COMBINED);
    c_attention_seen: cover property (@(posedge clock) disable iff (reset)
        $rose(attention));
endmodule : uhp_host

// file: sim/uhp_device_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// behavioural uart device on the parallel host bus
// ------------------------------------------------------------
module uhp_device_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // bus pins from the host
    input wire logic bus_style_strap,
    input wire logic [2:0] register_select,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] host_data_bus_out,
    output logic [7:0] dev_data,
    // device state set by the bench
    input wire logic slow,
    input wire logic irq_pending,
    input wire logic int_enable,
    input wire logic infrared,
    input wire logic tx_busy,
    output logic attention_pin,
    output logic tx_pin
);
    logic [7:0] regs [8];
    logic [7:0] last;
    logic [7:0] data_q;
    logic [2:0] sel_q;
    logic rd_now, rd_late, drive, cs_q, wr_q, float_bit;

    // ------------------------------------------------------------
    // read path, released bus shows the inverse of the last byte
    // ------------------------------------------------------------
    assign rd_now = !chip_select_n
        && (bus_style_strap ? !read_strobe_n : write_strobe_n);
    assign #20 rd_late = rd_now;
    assign drive = slow ? (rd_now && rd_late) : rd_now;
    assign dev_data = drive ? regs[register_select] : ~last;

    // ------------------------------------------------------------
    // write path on strobe or chip select rising
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cs_q <= chip_select_n;
        wr_q <= write_strobe_n;
        sel_q <= register_select;
        data_q <= host_data_bus_out;
        float_bit <= ~float_bit;
        if (drive) begin
            last <= regs[register_select];
        end
        if (reset) begin
            cs_q <= 1'b1;
            wr_q <= 1'b1;
            last <= 8'h00;
            float_bit <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (bus_style_strap && !cs_q && !wr_q && write_strobe_n) begin
            regs[sel_q] <= data_q;
        end else if (!bus_style_strap && !cs_q && chip_select_n && !wr_q) begin
            regs[sel_q] <= data_q;
        end
    end

    // ------------------------------------------------------------
    // interrupt and transmit pins
    // ------------------------------------------------------------
    always_comb begin
        if (bus_style_strap) begin
            attention_pin = int_enable ? irq_pending : float_bit;
        end else begin
            attention_pin = irq_pending ? 1'b0 : 1'b1;
        end
        tx_pin = infrared ? 1'b0 : 1'b1;
        if (tx_busy) begin
            tx_pin = ~tx_pin;
        end
    end
endmodule : uhp_device_model

// file: sim/uart_host_bus_port_tb.sv
`timescale 1ns/10ps
module uart_host_bus_port_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, style_separate = 1'b1, int_en = 1'b0, irda = 1'b0;
    logic slow = 1'b0, irq = 1'b0, tx_busy = 1'b0;
    logic [2:0] cmd_select = 3'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, cmd_done, attention, tx_idle_ok, bus_style_strap, chip_select_n;
    logic read_strobe_n, write_strobe_n, host_data_bus_oe_n, attention_pin, tx_pin;
    logic [7:0] cmd_rdata, host_data_bus_in, host_data_bus_out, dev_data;
    logic [2:0] register_select;
    int mismatches = 0;
    int comparisons = 0;
    int bad_r5 = 0;
    int bad_r15 = 0;

    always #20 clock = ~clock;
    assign host_data_bus_in = host_data_bus_oe_n ? dev_data : host_data_bus_out;

    uhp_host DUT (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_select(cmd_select), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .style_separate(style_separate),
        .attention_output_enable(int_en), .infrared_select(irda), .attention(attention),
        .tx_idle_ok(tx_idle_ok), .bus_style_strap(bus_style_strap),
        .register_select(register_select), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe_n(host_data_bus_oe_n), .attention_pin(attention_pin), .tx_pin(tx_pin));

    uhp_device_model device (.clock(clock), .reset(reset), .bus_style_strap(bus_style_strap),
        .register_select(register_select), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .host_data_bus_out(host_data_bus_out), .dev_data(dev_data), .slow(slow),
        .irq_pending(irq), .int_enable(int_en), .infrared(irda), .tx_busy(tx_busy),
        .attention_pin(attention_pin), .tx_pin(tx_pin));

    // ------------------------------------------------------------
    // pin monitors
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!reset && bus_style_strap === 1'b0 && read_strobe_n !== 1'b1) begin
            bad_r5++;
        end
        if (!reset && chip_select_n === 1'b1 && (read_strobe_n === 1'b0
            || (bus_style_strap === 1'b1 && write_strobe_n === 1'b0))) begin
            bad_r15++;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic xfer(input logic wr, input logic [2:0] sel, input logic [7:0] wd,
        output logic [7:0] rd);
        int n;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_select <= sel;
        cmd_wdata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_ready !== 1'b1 && n < 20);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_done !== 1'b1 && n < 20);
        check("cmd_done", {7'h0, cmd_done}, 8'h01);
        rd = cmd_rdata;
    endtask : xfer

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (6) @(posedge clock);
        check("cmd_ready", {7'h0, cmd_ready}, 8'h01);
        check("chip_select_n", {7'h0, chip_select_n}, 8'h01);
        check("strap", {7'h0, bus_style_strap}, 8'h01);
        check("strobes", {6'h0, read_strobe_n, write_strobe_n}, 8'h03);
        check("oe_n", {7'h0, host_data_bus_oe_n}, 8'h01);
        check("tx_idle_ok", {7'h0, tx_idle_ok}, 8'h01);
    endtask : t_reset

    task automatic t_regs(input logic style, input logic late);
        logic [7:0] rd;
        style_separate <= style;
        slow <= late;
        repeat (3) @(posedge clock);
        check("strap", {7'h0, bus_style_strap}, {7'h0, style});
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 3'(i), 8'(i * 8'h25) ^ {7'h0, style}, rd);
            check("stored", device.regs[i], 8'(i * 8'h25) ^ {7'h0, style});
        end
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b0, 3'(i), 8'h5a, rd);
            check("read", rd, 8'(i * 8'h25) ^ {7'h0, style});
            check("kept", device.regs[i], 8'(i * 8'h25) ^ {7'h0, style});
        end
        check("rd_idle", 8'(bad_r5), 8'h00);
        check("cs_idle", 8'(bad_r15), 8'h00);
    endtask : t_regs

    task automatic t_attention(input logic style);
        style_separate <= style;
        for (int i = 0; i < 4; i++) begin
            irq <= i[0];
            int_en <= i[1];
            repeat (8) @(posedge clock);
            check("attention", {7'h0, attention}, {7'h0, i[0] & (i[1] | !style)});
        end
    endtask : t_attention

    task automatic t_tx;
        for (int i = 0; i < 4; i++) begin
            irda <= i[0];
            tx_busy <= i[1];
            repeat (8) @(posedge clock);
            check("tx_idle_ok", {7'h0, tx_idle_ok}, {7'h0, !i[1]});
        end
    endtask : t_tx

    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_regs(1'b1, 1'b0);
        t_regs(1'b0, 1'b1);
        t_regs(1'b1, 1'b1);
        t_attention(1'b1);
        t_attention(1'b0);
        t_tx();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        summarize();
    end
endmodule : uart_host_bus_port_tb
